// ### usbf_pkg.sv
// USB function register block: constants, field positions and carrier types.
// Assumes a 40 MHz system clock and a serial engine that decodes packets.
package usbf_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_LINE_DRV = 32'h0008003C;
  localparam logic [31:0] ADDR_FUNC_ADDR = 32'h000E0000;
  localparam logic [31:0] ADDR_IRQ_CFG = 32'h000E0004;
  localparam logic [31:0] ADDR_BUS_CTRL = 32'h000E0008;
  localparam logic [31:0] ADDR_EV1 = 32'h000E000C;
  localparam logic [31:0] ADDR_EV1_MSK = 32'h000E0010;
  localparam logic [31:0] ADDR_EV2 = 32'h000E0014;
  localparam logic [31:0] ADDR_EV2_MSK = 32'h000E0018;
  localparam logic [31:0] ADDR_OUT_SEL = 32'h000E0020;
  localparam logic [31:0] ADDR_OUT_DATA = 32'h000E0024;
  localparam logic [31:0] ADDR_OUT_CMD = 32'h000E0028;
  localparam logic [31:0] ADDR_OUT_STAT = 32'h000E002C;
  localparam logic [31:0] ADDR_IN_SEL = 32'h000E0030;
  localparam logic [31:0] ADDR_IN_DATA = 32'h000E0034;
  localparam logic [31:0] ADDR_IN_CMD = 32'h000E0038;
  localparam logic [31:0] ADDR_IN_STAT = 32'h000E003C;
  localparam logic [31:0] ADDR_OUT_EN = 32'h000E0040;
  localparam logic [31:0] ADDR_OUT_EV = 32'h000E0050;
  localparam logic [31:0] ADDR_OUT_EV_MSK = 32'h000E0054;
  localparam logic [31:0] ADDR_IN_EV = 32'h000E0058;
  localparam logic [31:0] ADDR_IN_EV_MSK = 32'h000E005C;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CFG_POL_BIT = 0;
  localparam int CFG_EN_BIT = 1;
  localparam int CTRL_RESUME_BIT = 0;
  localparam int CTRL_ATTACH_BIT = 1;
  localparam int CTRL_SUSP_BIT = 2;
  localparam int EV1_LEVEL2_BIT = 0;
  localparam int EV1_ZLP_BIT = 2;
  localparam int EV1_IN_BIT = 4;
  localparam int EV1_OUT_BIT = 5;
  localparam int EV2_RESET_BIT = 0;
  localparam int EV2_SUSP_BIT = 1;
  localparam int EV2_RESUME_BIT = 2;
  localparam int EV2_WAKE_BIT = 3;
  localparam int EV2_DONE_BIT = 4;
  localparam int OSTAT_SETUP_BIT = 7;
  localparam int CMD_FLUSH_BIT = 0;
  localparam logic [7:0] EV1_IMPL_MASK = 8'h35;
  localparam logic [5:0] MODULE_VERSION = 6'h01; // Arbitrary value
  localparam logic DRV_WAKE_RESET = 1'b1;
  localparam logic [4:0] OUT_EN_RESET = 5'h00;

  // ----------------------------------------
  // Endpoints and FIFO depths
  // ----------------------------------------
  localparam int NUM_EP = 5;
  localparam logic [6:0] EP0_DEPTH = 7'h10;
  localparam logic [6:0] EPN_DEPTH = 7'h40;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint unsigned CLK_HZ = 40000000;
  localparam longint unsigned RESUME_K_MS = 12;
  localparam longint unsigned SUSP_GAP_MS = 5;
  localparam int unsigned RESUME_K_CYC = int'(RESUME_K_MS * CLK_HZ / 1000);
  localparam int unsigned SUSP_GAP_CYC = int'((SUSP_GAP_MS * CLK_HZ + 999) / 1000);

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_WAIT = 3'b010,
    RS_DRIVE = 3'b100
  } usbf_rs_e;

  typedef struct packed {
    logic tok_valid;
    logic tok_setup;
    logic [6:0] tok_addr;
    logic [3:0] tok_ep;
    logic dat_valid;
    logic [7:0] dat_byte;
    logic pkt_end;
    logic pkt_ok;
    logic pkt_data1;
    logic in_rd;
    logic [2:0] in_ep;
    logic [5:0] in_idx;
    logic in_done;
    logic usb_rst;
    logic suspend_det;
    logic bus_activity;
    logic resume_end;
    logic remote_wake;
  } usbf_rx_s;

  typedef struct packed {
    logic hs_valid;
    logic hs_ack;
    logic [7:0] in_data;
    logic [6:0] in_cnt;
  } usbf_tx_s;

  typedef struct packed {
    logic rxd;
    logic rxdp;
    logic rxdn;
  } usbf_line_in_s;

  typedef struct packed {
    logic oe;
    logic dp;
    logic dm;
  } usbf_line_out_s;

endpackage : usbf_pkg

// ### usbf_regs.sv
// USB function register block: software registers, endpoint FIFOs,
// handshake policy, event and interrupt logic, resume and attach control.
// Assumes a serial engine delivering decoded tokens and bytes synchronous to i_clk.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module usbf_regs
  import usbf_pkg::*;
#(
  parameter int unsigned P_RESUME_K_CYC = RESUME_K_CYC,
  parameter int unsigned P_SUSP_GAP_CYC = SUSP_GAP_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Serial engine side
  input usbf_rx_s i_rx,
  input usbf_line_in_s i_line,
  output usbf_tx_s o_tx,
  output usbf_line_out_s o_line,
  // Misc outputs
  output logic o_irq,
  output logic o_wakeup_gen
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_pipe_q;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic drv_wake_q;
  logic [6:0] func_addr_q;
  logic cfg_pol_q, cfg_en_q;
  logic ctrl_resume_q, ctrl_attach_q, ctrl_susp_q;
  logic [7:0] ev1_q, ev1_msk_q;
  logic [4:0] ev2_q, ev2_msk_q;
  logic [3:0] out_sel_q, in_sel_q;
  logic [4:0] out_en_q;
  logic [4:0] oev_q, oev_msk_q, iev_q, iev_msk_q;
  logic [6:0] out_cnt_q [NUM_EP];
  logic [4:0] out_blk_q;
  logic [6:0] out_rptr_q;
  logic setup_flag_q;
  logic [6:0] in_cnt_q [NUM_EP];
  logic [7:0] out_mem [NUM_EP][64];
  logic [7:0] in_mem [NUM_EP][64];
  logic tr_act_q, tr_setup_q, tr_en_q, tr_acc_q;
  logic [2:0] tr_ep_q;
  logic [6:0] tr_len_q;
  usbf_rs_e rs_q;
  logic [31:0] rs_cnt_q, susp_tmr_q;
  logic resume_pend_q;
  logic [31:0] rd_d;

  function automatic logic [6:0] ep_cap(input logic [2:0] ep);
    return (ep == 3'h0) ? EP0_DEPTH : EPN_DEPTH;
  endfunction : ep_cap

  // Register port decode
  logic wr_func, wr_cfg, wr_ctrl, wr_ev1m, wr_ev2m, wr_osel, wr_ocmd, wr_isel;
  logic wr_idata, wr_icmd, wr_oen, wr_oevm, wr_ievm, wr_drv;
  logic rd_ev1, rd_ev2, rd_oev, rd_iev, rd_odata;
  assign wr_drv = i_wr && (i_addr == ADDR_LINE_DRV);
  assign wr_func = i_wr && (i_addr == ADDR_FUNC_ADDR);
  assign wr_cfg = i_wr && (i_addr == ADDR_IRQ_CFG);
  assign wr_ctrl = i_wr && (i_addr == ADDR_BUS_CTRL);
  assign wr_ev1m = i_wr && (i_addr == ADDR_EV1_MSK);
  assign wr_ev2m = i_wr && (i_addr == ADDR_EV2_MSK);
  assign wr_osel = i_wr && (i_addr == ADDR_OUT_SEL);
  assign wr_ocmd = i_wr && (i_addr == ADDR_OUT_CMD) && i_wdata[CMD_FLUSH_BIT];
  assign wr_isel = i_wr && (i_addr == ADDR_IN_SEL);
  assign wr_idata = i_wr && (i_addr == ADDR_IN_DATA);
  assign wr_icmd = i_wr && (i_addr == ADDR_IN_CMD) && i_wdata[CMD_FLUSH_BIT];
  assign wr_oen = i_wr && (i_addr == ADDR_OUT_EN);
  assign wr_oevm = i_wr && (i_addr == ADDR_OUT_EV_MSK);
  assign wr_ievm = i_wr && (i_addr == ADDR_IN_EV_MSK);
  assign rd_ev1 = i_rd && (i_addr == ADDR_EV1);
  assign rd_ev2 = i_rd && (i_addr == ADDR_EV2);
  assign rd_oev = i_rd && (i_addr == ADDR_OUT_EV);
  assign rd_iev = i_rd && (i_addr == ADDR_IN_EV);
  assign rd_odata = i_rd && (i_addr == ADDR_OUT_DATA);

  logic osel_ok, isel_ok;
  logic [2:0] osel, isel;
  assign osel_ok = out_sel_q < 4'h5;
  assign isel_ok = in_sel_q < 4'h5;
  assign osel = out_sel_q[2:0];
  assign isel = in_sel_q[2:0];

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_wake_q <= DRV_WAKE_RESET;
      func_addr_q <= 7'h00;
      cfg_pol_q <= 1'b0;
      cfg_en_q <= 1'b0;
      ev1_msk_q <= 8'h00;
      ev2_msk_q <= 5'h00;
      out_sel_q <= 4'h0;
      in_sel_q <= 4'h0;
      oev_msk_q <= 5'h00;
      iev_msk_q <= 5'h00;
    end else begin
      if (wr_drv) drv_wake_q <= i_wdata[0];
      if (wr_func) func_addr_q <= i_wdata[6:0];
      if (wr_cfg) begin
        cfg_pol_q <= i_wdata[CFG_POL_BIT];
        cfg_en_q <= i_wdata[CFG_EN_BIT];
      end
      if (wr_ev1m) ev1_msk_q <= i_wdata[7:0] & EV1_IMPL_MASK;
      if (wr_ev2m) ev2_msk_q <= i_wdata[4:0];
      if (wr_osel) out_sel_q <= i_wdata[3:0];
      if (wr_isel) in_sel_q <= i_wdata[3:0];
      if (wr_oevm) oev_msk_q <= i_wdata[4:0];
      if (wr_ievm) iev_msk_q <= i_wdata[4:0];
    end
  end

  // Endpoint 0 enable forced on bus reset; beats a same-cycle software write
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_q <= OUT_EN_RESET;
    end else begin
      if (wr_oen) out_en_q <= i_wdata[4:0];
      if (i_rx.usb_rst) out_en_q[0] <= 1'b1;
    end
  end

  // ----------------------------------------
  // OUT transaction tracking
  // ----------------------------------------
  logic tok_hit, tok_en;
  logic [2:0] tok_ep;
  logic commit, zlp0;
  assign tok_ep = i_rx.tok_ep[2:0];
  assign tok_hit = i_rx.tok_valid && (i_rx.tok_addr == func_addr_q) && (i_rx.tok_ep < 4'h5);
  // SETUP only exists on the control endpoint
  assign tok_en = i_rx.tok_setup ? (tok_ep == 3'h0) : out_en_q[tok_ep];
  assign commit = tr_act_q && i_rx.pkt_end && i_rx.pkt_ok && tr_acc_q;
  assign zlp0 = (tr_len_q == 7'h00) && i_rx.pkt_data1 && (tr_ep_q == 3'h0) && !tr_setup_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tr_act_q <= 1'b0;
      tr_setup_q <= 1'b0;
      tr_en_q <= 1'b0;
      tr_acc_q <= 1'b0;
      tr_ep_q <= 3'h0;
      tr_len_q <= 7'h00;
    end else if (tok_hit) begin
      tr_act_q <= 1'b1;
      tr_setup_q <= i_rx.tok_setup;
      tr_ep_q <= tok_ep;
      tr_en_q <= tok_en;
      tr_acc_q <= tok_en && !out_blk_q[tok_ep];
      tr_len_q <= 7'h00;
    end else if (tr_act_q && i_rx.pkt_end) begin
      tr_act_q <= 1'b0;
    end else if (tr_act_q && tr_acc_q && i_rx.dat_valid && (tr_len_q < ep_cap(tr_ep_q))) begin
      tr_len_q <= tr_len_q + 7'h01;
    end
  end

  // Bytes land past the committed count; a bad packet is simply never committed
  always_ff @(posedge i_clk) begin
    if (tr_act_q && tr_acc_q && i_rx.dat_valid && (tr_len_q < ep_cap(tr_ep_q))) begin
      out_mem[tr_ep_q][tr_len_q[5:0]] <= i_rx.dat_byte;
    end
  end

  // Handshake: ACK on accept, NAK when enabled but blocked, silence for disabled endpoints and blocked SETUP
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx.hs_valid <= 1'b0;
      o_tx.hs_ack <= 1'b0;
    end else begin
      o_tx.hs_valid <= 1'b0;
      o_tx.hs_ack <= 1'b0;
      if (tr_act_q && i_rx.pkt_end && i_rx.pkt_ok) begin
        if (tr_acc_q) begin
          o_tx.hs_valid <= 1'b1;
          o_tx.hs_ack <= 1'b1;
        end else if (tr_en_q && !tr_setup_q) begin
          o_tx.hs_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Per-endpoint FIFO state
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      logic out_flush, out_commit, in_flush, in_push;
      assign out_flush = wr_ocmd && osel_ok && (osel == 3'(g));
      assign out_commit = commit && (tr_ep_q == 3'(g));
      assign in_flush = (wr_icmd && isel_ok && (isel == 3'(g))) || (i_rx.in_done && (i_rx.in_ep == 3'(g)));
      assign in_push = wr_idata && isel_ok && (isel == 3'(g)) && (in_cnt_q[g] < ep_cap(3'(g)));

      // A packet committing in the flush cycle survives the flush
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          out_cnt_q[g] <= 7'h00;
          out_blk_q[g] <= 1'b0;
        end else begin
          if (out_flush) begin
            out_cnt_q[g] <= 7'h00;
            out_blk_q[g] <= 1'b0;
          end
          if (out_commit) begin
            out_cnt_q[g] <= tr_len_q;
            out_blk_q[g] <= !zlp0;
          end
        end
      end

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          in_cnt_q[g] <= 7'h00;
        end else if (in_flush) begin
          in_cnt_q[g] <= 7'h00;
        end else if (in_push) begin
          in_cnt_q[g] <= in_cnt_q[g] + 7'h01;
        end
      end

      always_ff @(posedge i_clk) begin
        if (in_push) in_mem[g][in_cnt_q[g][5:0]] <= i_wdata[7:0];
      end
    end
  endgenerate

  // Read pointer of the selected OUT FIFO
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_rptr_q <= 7'h00;
    end else if (wr_osel || wr_ocmd) begin
      out_rptr_q <= 7'h00;
    end else if (rd_odata && osel_ok && (out_rptr_q < out_cnt_q[osel])) begin
      out_rptr_q <= out_rptr_q + 7'h01;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_flag_q <= 1'b0;
    end else if (commit && tr_setup_q) begin
      setup_flag_q <= 1'b1;
    end else if (wr_ocmd && (out_sel_q == 4'h0)) begin
      setup_flag_q <= 1'b0;
    end
  end

  // IN FIFO fetch for the serial engine
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx.in_data <= 8'h00;
      o_tx.in_cnt <= 7'h00;
    end else if (i_rx.in_rd && (i_rx.in_ep < 3'h5)) begin
      o_tx.in_data <= in_mem[i_rx.in_ep][i_rx.in_idx];
      o_tx.in_cnt <= in_cnt_q[i_rx.in_ep];
    end
  end

  // ----------------------------------------
  // Events
  // ----------------------------------------
  logic [4:0] oev_set, iev_set, ev2_set;
  logic [7:0] ev1_set;
  always_comb begin
    oev_set = 5'h00;
    iev_set = 5'h00;
    if (commit) oev_set[tr_ep_q] = 1'b1;
    if (i_rx.in_done && (i_rx.in_ep < 3'h5)) iev_set[i_rx.in_ep] = 1'b1;
    ev2_set = 5'h00;
    ev2_set[EV2_RESET_BIT] = i_rx.usb_rst;
    ev2_set[EV2_SUSP_BIT] = i_rx.suspend_det;
    ev2_set[EV2_RESUME_BIT] = ctrl_susp_q && i_rx.bus_activity;
    ev2_set[EV2_WAKE_BIT] = i_rx.remote_wake;
    ev2_set[EV2_DONE_BIT] = (resume_pend_q && i_rx.resume_end) || ((rs_q == RS_DRIVE) && (rs_cnt_q >= P_RESUME_K_CYC - 1));
    ev1_set = 8'h00;
    ev1_set[EV1_LEVEL2_BIT] = |(ev2_set & ~ev2_q & ev2_msk_q);
    ev1_set[EV1_ZLP_BIT] = commit && zlp0;
    ev1_set[EV1_IN_BIT] = |(iev_set & ~iev_q & iev_msk_q);
    ev1_set[EV1_OUT_BIT] = |(oev_set & ~oev_q & oev_msk_q);
  end

  // Clear on read; a set in the read cycle wins
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev1_q <= 8'h00;
      ev2_q <= 5'h00;
      oev_q <= 5'h00;
      iev_q <= 5'h00;
    end else begin
      ev1_q <= (rd_ev1 ? 8'h00 : ev1_q) | ev1_set;
      ev2_q <= (rd_ev2 ? 5'h00 : ev2_q) | ev2_set;
      oev_q <= (rd_oev ? 5'h00 : oev_q) | oev_set;
      iev_q <= (rd_iev ? 5'h00 : iev_q) | iev_set;
    end
  end

  // Level interrupt; enabling with pending events fires next edge
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b1;
    end else begin
      o_irq <= cfg_pol_q ~^ (cfg_en_q && |(ev1_q & ev1_msk_q));
    end
  end

  // ----------------------------------------
  // Suspend, resume and attach
  // ----------------------------------------
  logic gap_ok;
  assign gap_ok = susp_tmr_q >= P_SUSP_GAP_CYC;

  // Time since suspend began; saturates so idle long after suspend never waits
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      susp_tmr_q <= P_SUSP_GAP_CYC;
    end else if (i_rx.suspend_det) begin
      susp_tmr_q <= 32'h00000000;
    end else if (!gap_ok) begin
      susp_tmr_q <= susp_tmr_q + 32'h00000001;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q <= RS_IDLE;
      rs_cnt_q <= 32'h00000000;
    end else begin
      unique case (rs_q)
        RS_IDLE: begin
          rs_cnt_q <= 32'h00000000;
          if (ctrl_resume_q) rs_q <= gap_ok ? RS_DRIVE : RS_WAIT;
        end
        RS_WAIT: begin
          if (gap_ok) rs_q <= RS_DRIVE;
        end
        RS_DRIVE: begin
          rs_cnt_q <= rs_cnt_q + 32'h00000001;
          if (rs_cnt_q >= P_RESUME_K_CYC - 1) rs_q <= RS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      resume_pend_q <= 1'b0;
    end else if (resume_pend_q && i_rx.resume_end) begin
      resume_pend_q <= 1'b0;
    end else if (ctrl_susp_q && i_rx.bus_activity) begin
      resume_pend_q <= 1'b1;
    end
  end

  // Hardware clears resume after the K period and suspend after a resume
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_resume_q <= 1'b0;
      ctrl_attach_q <= 1'b0;
      ctrl_susp_q <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_resume_q <= i_wdata[CTRL_RESUME_BIT];
      ctrl_attach_q <= i_wdata[CTRL_ATTACH_BIT];
      ctrl_susp_q <= i_wdata[CTRL_SUSP_BIT];
    end else if (ev2_set[EV2_DONE_BIT]) begin
      ctrl_resume_q <= 1'b0;
      ctrl_susp_q <= 1'b0;
    end
  end

  // Detached: SE0 held; resume: K is D+ low, D- high
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_line <= '{oe: 1'b1, dp: 1'b0, dm: 1'b0};
      o_wakeup_gen <= DRV_WAKE_RESET;
    end else begin
      o_line.oe <= !ctrl_attach_q || (rs_q == RS_DRIVE);
      o_line.dp <= 1'b0;
      o_line.dm <= ctrl_attach_q && (rs_q == RS_DRIVE);
      o_wakeup_gen <= drv_wake_q;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rd_d = 32'h00000000;
    unique case (i_addr)
      ADDR_LINE_DRV: rd_d[3:0] = {i_line.rxdn, i_line.rxdp, i_line.rxd, drv_wake_q};
      ADDR_FUNC_ADDR: rd_d[6:0] = func_addr_q;
      ADDR_IRQ_CFG: rd_d[7:0] = {MODULE_VERSION, cfg_en_q, cfg_pol_q};
      ADDR_BUS_CTRL: rd_d[2:0] = {ctrl_susp_q, ctrl_attach_q, ctrl_resume_q};
      ADDR_EV1: rd_d[7:0] = ev1_q;
      ADDR_EV1_MSK: rd_d[7:0] = ev1_msk_q;
      ADDR_EV2: rd_d[4:0] = ev2_q;
      ADDR_EV2_MSK: rd_d[4:0] = ev2_msk_q;
      ADDR_OUT_SEL: rd_d[3:0] = out_sel_q;
      ADDR_OUT_DATA: if (osel_ok) rd_d[7:0] = out_mem[osel][out_rptr_q[5:0]];
      ADDR_OUT_STAT: if (osel_ok) rd_d[7:0] = {(osel == 3'h0) && setup_flag_q, out_cnt_q[osel]};
      ADDR_IN_SEL: rd_d[3:0] = in_sel_q;
      ADDR_IN_STAT: if (isel_ok) rd_d[6:0] = in_cnt_q[isel];
      ADDR_OUT_EN: rd_d[4:0] = out_en_q;
      ADDR_OUT_EV: rd_d[4:0] = oev_q;
      ADDR_OUT_EV_MSK: rd_d[4:0] = oev_msk_q;
      ADDR_IN_EV: rd_d[4:0] = iev_q;
      ADDR_IN_EV_MSK: rd_d[4:0] = iev_msk_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= i_rd ? rd_d : 32'h00000000;
    end
  end

endmodule : usbf_regs

// ### usbf_regs_assertions.sv
// Port checker for usbf_regs.
// Assumes a bind from the bench top.
`timescale 1ns/1ps
module usbf_chk
  import usbf_pkg::*;
#(
  parameter int unsigned P_RESUME_K_CYC = RESUME_K_CYC,
  parameter int unsigned P_SUSP_GAP_CYC = SUSP_GAP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata,
  input usbf_rx_s i_rx,
  input usbf_tx_s o_tx,
  input usbf_line_out_s o_line,
  input wire logic o_irq
);
  logic [31:0] k_q;
  logic [1:0] cfg_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) k_q <= '0;
    else k_q <= o_line.dm ? k_q + 1 : '0;
  end
  // Shadow of enable and polarity, same edge as the design
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) cfg_q <= '0;
    else if (i_wr && i_addr == ADDR_IRQ_CFG) cfg_q <= i_wdata[1:0];
  end
  // ----
  // Assertions
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == '0) else $error("stray read data");
  AST_HS_SLOT: assert property (o_tx.hs_valid |-> $past(i_rx.pkt_end)) else $error("late handshake");
  AST_HS_ONE: assert property (o_tx.hs_valid |=> !o_tx.hs_valid) else $error("long handshake");
  AST_BAD_CRC: assert property (i_rx.pkt_end && !i_rx.pkt_ok |=> !o_tx.hs_valid) else $error("bad crc answered");
  AST_K_LEN: assert property ($fell(o_line.dm) |-> k_q == P_RESUME_K_CYC) else $error("K length");
  AST_K_LEVEL: assert property (o_line.dm |-> o_line.oe && !o_line.dp) else $error("K level");
  AST_DETACH: assert property (i_wr && i_addr == ADDR_BUS_CTRL && !i_wdata[1] |-> ##2 o_line.oe && !o_line.dp)
    else $error("lines not low");
  AST_IRQ_IDLE: assert property (!cfg_q[1] && $stable(cfg_q) |-> o_irq == !cfg_q[0]) else $error("irq level");
  cover property (o_tx.hs_valid && o_tx.hs_ack);
  cover property (o_tx.hs_valid && !o_tx.hs_ack);
  cover property ($rose(o_line.dm));
endmodule : usbf_chk

// ### usbf_host.sv
// Behavioural USB host feeding decoded bus events.
// Assumes one calling thread in the bench.
`timescale 1ns/1ps
module usbf_host
  import usbf_pkg::*;
(
  input wire logic i_clk,
  input usbf_tx_s i_tx,
  output usbf_rx_s o_rx,
  output usbf_line_in_s o_line
);
  initial o_rx = '0;
  initial o_line = 3'h2;
  task automatic pulse(input usbf_rx_s r);
    @(posedge i_clk) o_rx <= r;
    @(posedge i_clk) o_rx <= '0;
    #1;
  endtask : pulse
  task automatic set_line(input usbf_line_in_s v);
    @(posedge i_clk) o_line <= v;
  endtask : set_line
  // Answer code: 3 ACK, 2 NAK, 0 silent
  task automatic xfer(input logic st, input logic [6:0] a, input logic [3:0] ep, input int n,
    input logic ok, output logic [1:0] hs);
    pulse('{tok_valid: 1'b1, tok_setup: st, tok_addr: a, tok_ep: ep, default: '0});
    for (int i = 0; i < n; i++) pulse('{dat_valid: 1'b1, dat_byte: 8'hA0 + 8'(i), default: '0});
    pulse('{pkt_end: 1'b1, pkt_ok: ok, pkt_data1: !st && n == 0, default: '0});
    hs = {i_tx.hs_valid, i_tx.hs_valid & i_tx.hs_ack};
  endtask : xfer
endmodule : usbf_host

// ### tb_usbf_regs.sv
// Bench for usbf_regs: register calls and host traffic.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module tb_usbf_regs;
  import usbf_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic [31:0] o_rdata;
  logic o_irq;
  logic o_wakeup_gen;
  logic [1:0] hs;
  usbf_rx_s i_rx;
  usbf_line_in_s i_line;
  usbf_tx_s o_tx;
  usbf_line_out_s o_line;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  always #12.5 i_clk = ~i_clk;
  usbf_regs #(.P_RESUME_K_CYC(20), .P_SUSP_GAP_CYC(10)) usbf_regs_i (.*);
  usbf_host usbf_host_i (.i_clk(i_clk), .i_tx(o_tx), .o_rx(i_rx), .o_line(i_line));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : w
  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rc
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    usbf_host_i.set_line(3'h5);
    repeat (2) @(posedge i_clk);
    #1 chk(32'(o_line), 32'h4);
    chk(o_wakeup_gen, 32'h1);
    rc(ADDR_FUNC_ADDR, 32'h0);
    rc(ADDR_IRQ_CFG, {24'h0, MODULE_VERSION, 2'h0});
    rc(ADDR_EV2_MSK, 32'h0);
    rc(32'h000E001C, 32'h0);
    rc(ADDR_LINE_DRV, 32'hB);
    w(ADDR_LINE_DRV, 32'h0);
    rc(ADDR_LINE_DRV, 32'hA);
    chk(o_wakeup_gen, 32'h0);
    $display("reset test done");
    w(ADDR_BUS_CTRL, 32'h2);
    w(ADDR_OUT_EN, 32'h2);
    w(ADDR_OUT_EV_MSK, 32'h2);
    w(ADDR_EV1_MSK, 32'h35);
    w(ADDR_EV2_MSK, 32'h1F);
    w(ADDR_IRQ_CFG, 32'h1);
    chk(o_line.oe, 32'h0);
    usbf_host_i.xfer(1'b0, 7'h00, 4'h1, 3, 1'b1, hs);
    chk(hs, 32'h3);
    usbf_host_i.xfer(1'b0, 7'h00, 4'h1, 3, 1'b1, hs);
    chk(hs, 32'h2);
    chk(o_irq, 32'h0);
    w(ADDR_IRQ_CFG, 32'h3);
    w(ADDR_OUT_SEL, 32'h1);
    chk(o_irq, 32'h1);
    rc(ADDR_OUT_STAT, 32'h3);
    for (int i = 0; i < 3; i++) rc(ADDR_OUT_DATA, 32'hA0 + i);
    rc(ADDR_OUT_EV, 32'h2);
    rc(ADDR_EV1, 32'h20);
    rc(ADDR_EV1, 32'h0);
    chk(o_irq, 32'h0);
    w(ADDR_OUT_CMD, 32'h1);
    w(ADDR_FUNC_ADDR, 32'h5);
    usbf_host_i.xfer(1'b0, 7'h00, 4'h1, 1, 1'b1, hs);
    chk(hs, 32'h0);
    usbf_host_i.xfer(1'b0, 7'h05, 4'h1, 1, 1'b0, hs);
    chk(hs, 32'h0);
    usbf_host_i.xfer(1'b0, 7'h05, 4'h1, 1, 1'b1, hs);
    chk(hs, 32'h3);
    usbf_host_i.pulse('{usb_rst: 1'b1, default: '0});
    rc(ADDR_OUT_EN, 32'h3);
    for (int i = 0; i < 2; i++) usbf_host_i.xfer(1'b0, 7'h05, 4'h0, 0, 1'b1, hs);
    chk(hs, 32'h3);
    rc(ADDR_EV1, 32'h25);
    usbf_host_i.xfer(1'b1, 7'h05, 4'h0, 2, 1'b1, hs);
    w(ADDR_OUT_SEL, 32'h0);
    rc(ADDR_OUT_STAT, 32'h82);
    usbf_host_i.xfer(1'b1, 7'h05, 4'h0, 2, 1'b1, hs);
    chk(hs, 32'h0);
    $display("out test done");
    w(ADDR_IN_SEL, 32'h1);
    for (int i = 0; i < 3; i++) w(ADDR_IN_DATA, 32'hC0 + i);
    rc(ADDR_IN_STAT, 32'h3);
    usbf_host_i.pulse('{in_rd: 1'b1, in_ep: 3'h1, in_idx: 6'h01, default: '0});
    chk(o_tx.in_data, 32'hC1);
    chk(o_tx.in_cnt, 32'h3);
    w(ADDR_IN_EV_MSK, 32'h2);
    usbf_host_i.pulse('{in_done: 1'b1, in_ep: 3'h1, default: '0});
    rc(ADDR_IN_EV, 32'h2);
    rc(ADDR_EV1, 32'h10);
    w(ADDR_BUS_CTRL, 32'h6);
    usbf_host_i.pulse('{suspend_det: 1'b1, default: '0});
    w(ADDR_BUS_CTRL, 32'h7);
    // Without the gap the K would already be on the lines here
    repeat (4) @(posedge i_clk);
    #1 chk(o_line.dm, 32'h0);
    repeat (12) @(posedge i_clk);
    #1 chk(32'(o_line), 32'h5);
    repeat (20) @(posedge i_clk);
    rc(ADDR_BUS_CTRL, 32'h2);
    w(ADDR_BUS_CTRL, 32'h6);
    usbf_host_i.pulse('{bus_activity: 1'b1, default: '0});
    rc(ADDR_BUS_CTRL, 32'h6);
    usbf_host_i.pulse('{resume_end: 1'b1, default: '0});
    rc(ADDR_BUS_CTRL, 32'h2);
    w(ADDR_BUS_CTRL, 32'h0);
    rc(ADDR_BUS_CTRL, 32'h0);
    chk(32'(o_line), 32'h4);
    $display("resume test done");
    print_verdict();
  end
endmodule : tb_usbf_regs
bind usbf_regs usbf_chk #(.P_RESUME_K_CYC(P_RESUME_K_CYC), .P_SUSP_GAP_CYC(P_SUSP_GAP_CYC)) usbf_chk_i (.*);
